// [hdl/csr_pkg.sv]
/*
 * shared constants and types for the clock, sleep and reset control block:
 * timing counts, register offsets and fields, enable masks, state codes.
 * assumes a 10 MHz bus clock and a 32-bit AHB-Lite register port.
 */
package csr_pkg;
    // timing
    localparam int unsigned T_CLK_NS = 100;
    localparam int unsigned RST_MIN_NS = 500;
    localparam logic [3:0] RST_MIN_CYC = 4'((RST_MIN_NS + T_CLK_NS - 1) / T_CLK_NS);

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SLEEP = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_FUSE = 8'h0C;

    // field positions
    localparam int CTRL_SLEEP_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int STATUS_SRC_LSB = 0;
    localparam int STATUS_STATE_LSB = 3;
    localparam int STATUS_PINRST_BIT = 5;

    // reset values
    localparam logic [3:0] FUSE_RESET = 4'hF;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // fuse range lower bounds
    localparam logic [3:0] FUSE_XTAL_MIN = 4'hA;
    localparam logic [3:0] FUSE_LFX_MIN = 4'h8;
    localparam logic [3:0] FUSE_EXTRC_MIN = 4'h5;
    localparam logic [3:0] FUSE_INTRC_MIN = 4'h2;

    // clock domain enable bits and masks per state
    localparam int EN_OSC = 0;
    localparam int EN_CPU = 1;
    localparam int EN_MEM = 2;
    localparam int EN_IO = 3;
    localparam int EN_ATMR = 4;
    localparam int EN_ADC = 5;
    localparam int EN_INT = 6;
    localparam int EN_W = 7;
    localparam logic [6:0] EN_RUN = 7'h7F;
    localparam logic [6:0] EN_NO_CPU = 7'h7D;
    localparam logic [6:0] EN_ADC_NR = 7'h75;
    localparam logic [6:0] EN_PSAVE = 7'h50;
    localparam logic [6:0] EN_PDOWN = 7'h40;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WAKE = 2'b10
    } st_t;

    typedef enum logic [1:0] {
        MODE_IDLE = 2'b00,
        MODE_ADC_NR = 2'b01,
        MODE_PWR_DOWN = 2'b10,
        MODE_PWR_SAVE = 2'b11
    } mode_t;

    typedef enum logic [2:0] {
        SRC_XTAL = 3'b000,
        SRC_LFXTAL = 3'b001,
        SRC_EXTRC = 3'b010,
        SRC_INTRC = 3'b011,
        SRC_EXTCLK = 3'b100
    } src_t;

    function automatic src_t src_of(input logic [3:0] f);
        if (f >= FUSE_XTAL_MIN) begin
            return SRC_XTAL;
        end else if (f >= FUSE_LFX_MIN) begin
            return SRC_LFXTAL;
        end else if (f >= FUSE_EXTRC_MIN) begin
            return SRC_EXTRC;
        end else if (f >= FUSE_INTRC_MIN) begin
            return SRC_INTRC;
        end
        return SRC_EXTCLK;
    endfunction
endpackage

// [hdl/reset_pin_filter.sv]
/*
 * reset pin qualifier: a low level held for the minimum pulse width
 * raises a reset level until the pin returns high.
 * assumes the pin is synchronous to hclk.
 */
`timescale 1ns/1ps
module reset_pin_filter
    import csr_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // pin and result
    input wire logic reset_pin_n,
    output logic pin_rst
);
    typedef struct packed {
        logic [3:0] cnt;
        logic rst;
    } flt_t;

    flt_t q;
    flt_t d;

    always_comb begin
        d = q;
        if (reset_pin_n) begin
            d.cnt = 4'h0;
        end else if (q.cnt < RST_MIN_CYC) begin
            d.cnt = q.cnt + 4'h1;
        end
        d.rst = (d.cnt >= RST_MIN_CYC);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pin_rst = q.rst;

    property p_min_low;
        @(posedge hclk) disable iff (!hresetn)
        (!reset_pin_n) [*5] |=> pin_rst;
    endproperty
    a_min_low: assert property (p_min_low) else $error("pin reset missing");
endmodule

// [hdl/ahb_reg_port.sv]
/*
 * AHB-Lite slave for the control registers: one wait state per transfer,
 * write strobe and read capture in the first data phase cycle.
 * assumes single word transfers and a single slave on the bus.
 */
`timescale 1ns/1ps
module ahb_reg_port
    import csr_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // register side
    output logic [7:0] reg_addr,
    output logic reg_mapped,
    output logic reg_wr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata
);
    typedef struct packed {
        logic pend;
        logic wr;
        logic mapped;
        logic [7:0] addr;
        logic ready;
        logic [31:0] rdata;
    } bus_t;

    bus_t q;
    bus_t d;

    always_comb begin
        d = q;
        d.pend = 1'b0;
        d.ready = 1'b1;
        if (q.pend) begin
            d.rdata = (!q.wr && q.mapped) ? reg_rdata : RDATA_RESET;
        end else if (hsel && htrans[1] && hready) begin
            d.pend = 1'b1;
            d.ready = 1'b0;
            d.wr = hwrite;
            d.addr = haddr[7:0];
            d.mapped = (haddr[31:8] == 24'h00_0000) && (hsize == 3'h2);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '{pend: 1'b0, wr: 1'b0, mapped: 1'b0, addr: 8'h00, ready: 1'b1,
                   rdata: RDATA_RESET};
        end else begin
            q <= d;
        end
    end

    assign hreadyout = q.ready;
    assign hrdata = q.rdata;
    assign hresp = 1'b0;
    assign reg_addr = q.addr;
    assign reg_mapped = q.mapped;
    assign reg_wr = q.pend && q.wr && q.mapped;
    assign reg_wdata = hwdata;
endmodule

// [hdl/clock_sleep_reset_control.sv]
/*
 * clock source selection, sleep mode clock gating and reset entry control.
 * assumes an AHB-Lite master for register access, a fuse field that is
 * static, and synchronous reset pin and wake request inputs.
 */
`timescale 1ns/1ps
module clock_sleep_reset_control
    import csr_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // pins and fuses
    input wire logic reset_pin_n,
    input wire logic [3:0] clock_source_select,
    input wire logic wake_irq,
    // clock source control
    output logic [2:0] clk_source,
    output logic main_osc_en,
    output logic int_rc_en,
    output logic xtal_amp_en,
    // domain clock enables
    output logic cpu_clk_en,
    output logic mem_clk_en,
    output logic io_clk_en,
    output logic async_timer_en,
    output logic adc_clk_en,
    output logic int_clk_en,
    // reset and status
    output logic ports_hiz,
    output logic core_reset,
    output logic sleeping
);
    typedef struct packed {
        st_t st;
        mode_t mode;
        logic sleep_en;
        logic [3:0] fuse;
        src_t src;
        logic pin_flag;
        logic [EN_W-1:0] en;
        logic int_rc;
        logic xamp;
        logic hiz;
        logic core_rst;
        logic slp;
    } ctl_t;

    localparam ctl_t CTL_RESET = '{
        st: ST_RUN,
        mode: MODE_IDLE,
        sleep_en: 1'b0,
        fuse: FUSE_RESET,
        src: SRC_XTAL,
        pin_flag: 1'b0,
        en: EN_RUN,
        int_rc: 1'b0,
        xamp: 1'b0,
        hiz: 1'b1,
        core_rst: 1'b1,
        slp: 1'b0
    };

    ctl_t q;
    ctl_t d;

    logic pin_rst;
    logic [7:0] reg_addr;
    logic reg_mapped;
    logic reg_wr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;

    ahb_reg_port u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .reg_addr(reg_addr),
        .reg_mapped(reg_mapped),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata)
    );

    reset_pin_filter u_rst (
        .hclk(hclk),
        .hresetn(hresetn),
        .reset_pin_n(reset_pin_n),
        .pin_rst(pin_rst)
    );

    logic wr_ctrl;
    logic wr_sleep;
    logic wr_status;

    assign wr_ctrl = reg_wr && reg_mapped && (reg_addr == ADDR_CTRL);
    assign wr_sleep = reg_wr && reg_mapped && (reg_addr == ADDR_SLEEP);
    assign wr_status = reg_wr && reg_mapped && (reg_addr == ADDR_STATUS);

    // read mux
    always_comb begin
        reg_rdata = 32'h0000_0000;
        case (reg_addr)
            ADDR_CTRL: begin
                reg_rdata[CTRL_SLEEP_EN_BIT] = q.sleep_en;
                reg_rdata[CTRL_MODE_LSB +: 2] = q.mode;
            end
            ADDR_STATUS: begin
                reg_rdata[STATUS_SRC_LSB +: 3] = q.src;
                reg_rdata[STATUS_STATE_LSB +: 2] = q.st;
                reg_rdata[STATUS_PINRST_BIT] = q.pin_flag;
            end
            ADDR_FUSE: begin
                reg_rdata[3:0] = q.fuse;
            end
            default: begin
                reg_rdata = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        d = q;
        d.core_rst = pin_rst;
        d.hiz = pin_rst;
        if (wr_status && reg_wdata[STATUS_PINRST_BIT]) begin
            d.pin_flag = 1'b0;
        end
        if (pin_rst) begin
            // set wins over a same-cycle clear
            d.pin_flag = 1'b1;
        end
        if (q.core_rst) begin
            d.fuse = clock_source_select;
        end
        d.src = src_of(d.fuse);
        if (pin_rst || q.core_rst) begin
            d.st = ST_RUN;
        end else begin
            case (q.st)
                ST_RUN: begin
                    if (wr_ctrl) begin
                        d.sleep_en = reg_wdata[CTRL_SLEEP_EN_BIT];
                        d.mode = mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]);
                    end
                    if (wr_sleep && q.sleep_en) begin
                        d.st = ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wake_irq) begin
                        d.st = ST_WAKE;
                    end
                end
                ST_WAKE: begin
                    d.st = ST_RUN;
                end
                default: begin
                    d.st = ST_RUN;
                end
            endcase
        end
        case (d.st)
            ST_SLEEP: begin
                case (d.mode)
                    MODE_IDLE: d.en = EN_NO_CPU;
                    MODE_ADC_NR: d.en = EN_ADC_NR;
                    MODE_PWR_SAVE: d.en = EN_PSAVE;
                    MODE_PWR_DOWN: d.en = EN_PDOWN;
                    default: d.en = EN_PDOWN;
                endcase
            end
            ST_WAKE: begin
                d.en = EN_NO_CPU;
            end
            default: begin
                d.en = EN_RUN;
            end
        endcase
        d.int_rc = d.en[EN_OSC] && (d.src == SRC_INTRC);
        d.xamp = d.en[EN_OSC] && (d.src inside {SRC_XTAL, SRC_LFXTAL, SRC_EXTRC});
        d.slp = (d.st == ST_SLEEP);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= CTL_RESET;
        end else begin
            q <= d;
        end
    end

    assign clk_source = q.src;
    assign main_osc_en = q.en[EN_OSC];
    assign int_rc_en = q.int_rc;
    assign xtal_amp_en = q.xamp;
    assign cpu_clk_en = q.en[EN_CPU];
    assign mem_clk_en = q.en[EN_MEM];
    assign io_clk_en = q.en[EN_IO];
    assign async_timer_en = q.en[EN_ATMR];
    assign adc_clk_en = q.en[EN_ADC];
    assign int_clk_en = q.en[EN_INT];
    assign ports_hiz = q.hiz;
    assign core_reset = q.core_rst;
    assign sleeping = q.slp;

    property p_src_xtal;
        @(posedge hclk) disable iff (!hresetn)
        (!core_reset && q.fuse >= 4'hA) |-> clk_source == SRC_XTAL;
    endproperty
    a_src_xtal: assert property (p_src_xtal) else $error("high fuse decode");

    property p_src_extclk;
        @(posedge hclk) disable iff (!hresetn)
        (q.fuse <= 4'h1 && $stable(q.fuse)) |-> clk_source == SRC_EXTCLK;
    endproperty
    a_src_extclk: assert property (p_src_extclk) else $error("low fuse decode");

    property p_int_rc;
        @(posedge hclk) disable iff (!hresetn)
        (clk_source == SRC_INTRC) |-> (int_rc_en == main_osc_en) && !xtal_amp_en;
    endproperty
    a_int_rc: assert property (p_int_rc) else $error("int RC enable wrong");

    property p_idle;
        @(posedge hclk) disable iff (!hresetn)
        (sleeping && q.mode == MODE_IDLE) |->
            !cpu_clk_en && mem_clk_en && io_clk_en && int_clk_en && main_osc_en;
    endproperty
    a_idle: assert property (p_idle) else $error("idle gating wrong");

    property p_pdown_hold;
        @(posedge hclk) disable iff (!hresetn)
        (sleeping && q.mode == MODE_PWR_DOWN && !wake_irq && !pin_rst) |=>
            sleeping && !main_osc_en && !async_timer_en && !cpu_clk_en;
    endproperty
    a_pdown_hold: assert property (p_pdown_hold) else $error("power-down wrong");

    property p_psave;
        @(posedge hclk) disable iff (!hresetn)
        (sleeping && q.mode == MODE_PWR_SAVE) |->
            async_timer_en && !main_osc_en && !io_clk_en && !adc_clk_en;
    endproperty
    a_psave: assert property (p_psave) else $error("power-save gating wrong");

    property p_adc_nr;
        @(posedge hclk) disable iff (!hresetn)
        (sleeping && q.mode == MODE_ADC_NR) |->
            adc_clk_en && async_timer_en && !io_clk_en && !cpu_clk_en;
    endproperty
    a_adc_nr: assert property (p_adc_nr) else $error("ADC sleep gating wrong");

    property p_hiz;
        @(posedge hclk) disable iff (!hresetn)
        pin_rst |=> ports_hiz && core_reset ##1 (ports_hiz || !pin_rst);
    endproperty
    a_hiz: assert property (p_hiz) else $error("ports not tristated in reset");

    property p_enter;
        @(posedge hclk) disable iff (!hresetn)
        (wr_sleep && q.sleep_en && q.st == ST_RUN && !pin_rst && !core_reset) |=>
            sleeping && !cpu_clk_en && (q.mode == $past(q.mode));
    endproperty
    a_enter: assert property (p_enter) else $error("sleep not entered");

    property p_wake;
        @(posedge hclk) disable iff (!hresetn)
        (sleeping && wake_irq && !pin_rst && !core_reset) |=>
            (main_osc_en && !cpu_clk_en) ##1 (cpu_clk_en || core_reset);
    endproperty
    a_wake: assert property (p_wake) else $error("wake order wrong");

    property p_fuse_fixed;
        @(posedge hclk) disable iff (!hresetn)
        (!core_reset && !$past(core_reset)) |-> $stable(q.fuse);
    endproperty
    a_fuse_fixed: assert property (p_fuse_fixed) else $error("fuse changed");
endmodule

// [verification/board_partner.sv]
/*
 * far side of the block: nonvolatile fuse field and an external reset
 * driver that pulls the reset pin low for a commanded number of cycles.
 * assumes the bench commands it on hclk rising edges.
 */
`timescale 1ns/1ps
module board_partner
    import csr_pkg::*;
(
    // clock
    input wire logic hclk,
    // commands from the bench
    input wire logic [3:0] fuse_value,
    input wire logic [3:0] low_cycles,
    input wire logic go,
    // device pins
    output logic reset_pin_n,
    output logic [3:0] clock_source_select
);
    logic [3:0] cnt_q = 4'h0;

    // held low for exactly the commanded count, pulled up otherwise
    always_ff @(posedge hclk) begin
        if (go && cnt_q == 4'h0) begin
            cnt_q <= low_cycles;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
    assign reset_pin_n = (cnt_q == 4'h0);
    assign clock_source_select = fuse_value;
endmodule

// [verification/test_clock_sleep_reset_control.sv]
/*
 * self-checking bench: fuse decode, sleep modes and wake, pin reset.
 * assumes the board partner model and a single AHB-Lite slave.
 */
`timescale 1ns/1ps
module test_clock_sleep_reset_control
    import csr_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, wake_irq, go;
    logic [31:0] haddr, hwdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] fuse_value, low_cycles, clock_source_select;
    logic hready, hreadyout, hresp, reset_pin_n;
    logic [31:0] hrdata;
    logic [2:0] clk_source;
    logic main_osc_en, int_rc_en, xtal_amp_en, cpu_clk_en, mem_clk_en, io_clk_en;
    logic async_timer_en, adc_clk_en, int_clk_en, ports_hiz, core_reset, sleeping;
    logic [6:0] en_vec;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    localparam logic [6:0] MODE_EN [4] = '{7'h7D, 7'h75, 7'h40, 7'h50};

    assign hready = hreadyout;
    assign en_vec = {int_clk_en, adc_clk_en, async_timer_en, io_clk_en, mem_clk_en,
                     cpu_clk_en, main_osc_en};

    clock_sleep_reset_control dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .reset_pin_n(reset_pin_n), .clock_source_select(clock_source_select),
        .wake_irq(wake_irq), .clk_source(clk_source), .main_osc_en(main_osc_en),
        .int_rc_en(int_rc_en), .xtal_amp_en(xtal_amp_en), .cpu_clk_en(cpu_clk_en),
        .mem_clk_en(mem_clk_en), .io_clk_en(io_clk_en), .async_timer_en(async_timer_en),
        .adc_clk_en(adc_clk_en), .int_clk_en(int_clk_en), .ports_hiz(ports_hiz),
        .core_reset(core_reset), .sleeping(sleeping));

    board_partner partner_u (.hclk(hclk), .fuse_value(fuse_value), .low_cycles(low_cycles),
        .go(go), .reset_pin_n(reset_pin_n), .clock_source_select(clock_source_select));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic complete_run();
        if (error_cnt == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc++;
        if (cyc > 3000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t bit %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= 32'(a);
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            @(posedge hclk);
        end
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            @(posedge hclk);
        end
        rd = hrdata;
    endtask

    task automatic do_reset(input logic [3:0] f);
        fuse_value <= f;
        hresetn <= 1'b0;
        tick(2);
        chk_bit(ports_hiz, 1'b1);
        chk_bit(core_reset, 1'b1);
        hresetn <= 1'b1;
        tick(2);
    endtask

    function automatic src_t exp_src(input logic [3:0] f);
        if (f >= 4'hA) return SRC_XTAL;
        if (f >= 4'h8) return SRC_LFXTAL;
        if (f >= 4'h5) return SRC_EXTRC;
        if (f >= 4'h2) return SRC_INTRC;
        return SRC_EXTCLK;
    endfunction

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        wake_irq = 1'b0;
        go = 1'b0;
        low_cycles = 4'h0;
        fuse_value = 4'hF;
        for (int f = 0; f < 16; f++) begin
            do_reset(4'(f));
            chk_word(32'(clk_source), 32'(exp_src(4'(f))));
            chk_bit(int_rc_en, exp_src(4'(f)) == SRC_INTRC);
            chk_bit(xtal_amp_en, exp_src(4'(f)) < SRC_INTRC);
            bus(1'b0, ADDR_FUSE, 32'h0000_0000);
            chk_word(rd, 32'(f));
            fuse_value <= ~4'(f);
            tick(3);
            chk_word(32'(clk_source), 32'(exp_src(4'(f))));
        end
        chk_word(32'(en_vec), 32'h0000_007F);
        chk_bit(ports_hiz, 1'b0);
        // sleep request refused without the enable, read of unused offset 0x10 gives zero
        bus(1'b1, ADDR_CTRL, 32'h0000_0000);
        bus(1'b1, ADDR_SLEEP, 32'h0000_0001);
        chk_bit(sleeping, 1'b0);
        bus(1'b0, 8'h10, 32'h0000_0000);
        chk_word(rd, 32'h0000_0000);
        chk_bit(hresp, 1'b0);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, ADDR_CTRL, 32'(m * 2 + 1));
            bus(1'b1, ADDR_SLEEP, 32'h0000_0001);
            tick(3);
            chk_bit(sleeping, 1'b1);
            chk_word(32'(en_vec), 32'(MODE_EN[m]));
            wake_irq <= 1'b1;
            tick(1);
            wake_irq <= 1'b0;
            tick(1);
            chk_word(32'(en_vec), 32'h0000_007D);
            chk_bit(sleeping, 1'b0);
            tick(1);
            chk_bit(cpu_clk_en, 1'b1);
            bus(1'b0, ADDR_CTRL, 32'h0000_0000);
            chk_word(rd, 32'(m * 2 + 1));
        end
        // pulse too short, then a long one that re-reads the fuse
        fuse_value <= 4'h3;
        low_cycles <= 4'h4;
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            tick(1);
            chk_bit(core_reset, 1'b0);
        end
        chk_word(32'(clk_source), 32'(SRC_XTAL));
        low_cycles <= 4'h8;
        go <= 1'b1;
        tick(1);
        go <= 1'b0;
        tick(6);
        chk_bit(core_reset, 1'b0);
        tick(1);
        chk_bit(core_reset, 1'b1);
        chk_bit(ports_hiz, 1'b1);
        tick(10);
        chk_word(32'(clk_source), 32'(SRC_INTRC));
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk_word(rd, 32'h0000_0023);
        bus(1'b1, ADDR_STATUS, 32'h0000_0020);
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk_word(rd, 32'h0000_0003);
        complete_run();
    end
endmodule
